//--- rtl/iorba_pkg.sv
// Constants, register map and operation codes of the lower I/O register bank
package iorba_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int REG_W = 8;
   localparam int NREG  = 32;
   localparam int BITS  = REG_W * NREG;

   // ---------------------------------------------------------------
   // Address windows
   // ---------------------------------------------------------------
   localparam logic [7:0] IO_TOP   = 8'h20;
   localparam logic [7:0] DATA_OFS = 8'h20;
   localparam logic [7:0] DATA_TOP = 8'h40;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [4:0] OFS_POWER_REDUCTION_CTRL   = 5'h00,
                          OFS_DIGITAL_INPUT_DISABLE  = 5'h01,
                          OFS_RESERVED_IO_02         = 5'h02,
                          OFS_CONVERTER_CTRL_B       = 5'h03,
                          OFS_CONVERTER_RESULT_LOW   = 5'h04,
                          OFS_CONVERTER_RESULT_HIGH  = 5'h05,
                          OFS_CONVERTER_CTRL_A       = 5'h06,
                          OFS_CONVERTER_CHANNEL_SEL  = 5'h07,
                          OFS_COMPARATOR_CTRL_STATUS = 5'h08,
                          OFS_RESERVED_IO_09         = 5'h09,
                          OFS_RESERVED_IO_0A         = 5'h0A,
                          OFS_TIMER1_INT_FLAGS       = 5'h0B,
                          OFS_TIMER1_INT_MASK        = 5'h0C,
                          OFS_SERIAL_UNIT_CTRL       = 5'h0D,
                          OFS_SERIAL_UNIT_STATUS     = 5'h0E,
                          OFS_SERIAL_UNIT_SHIFT_DATA = 5'h0F,
                          OFS_SERIAL_UNIT_BUFFER     = 5'h10,
                          OFS_RESERVED_IO_11         = 5'h11,
                          OFS_PIN_CHANGE_MASK_0      = 5'h12,
                          OFS_GENERAL_SCRATCH_0      = 5'h13,
                          OFS_GENERAL_SCRATCH_1      = 5'h14,
                          OFS_GENERAL_SCRATCH_2      = 5'h15,
                          OFS_PORT_B_INPUT           = 5'h16,
                          OFS_PORT_B_DIRECTION       = 5'h17,
                          OFS_PORT_B_OUTPUT          = 5'h18,
                          OFS_PORT_A_INPUT           = 5'h19,
                          OFS_PORT_A_DIRECTION       = 5'h1A,
                          OFS_PORT_A_OUTPUT          = 5'h1B,
                          OFS_NONVOLATILE_CTRL       = 5'h1C,
                          OFS_NONVOLATILE_DATA       = 5'h1D,
                          OFS_NONVOLATILE_ADDR_LOW   = 5'h1E,
                          OFS_NONVOLATILE_ADDR_HIGH  = 5'h1F;

   // ---------------------------------------------------------------
   // Bit kinds, byte 0x1F first; unlisted bits other than the port pin inputs are reserved, read zero
   // ---------------------------------------------------------------
   localparam logic [BITS-1:0] RW_ALL = {
      8'h01, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h0F,
      8'h0F, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00,
      8'hFF, 8'h0F, 8'hFF, 8'h27, 8'h00, 8'h00, 8'h00, 8'hCF,
      8'hFF, 8'hEF, 8'h00, 8'h00, 8'hD7, 8'h00, 8'hFF, 8'h0F};
   localparam logic [BITS-1:0] W1C_ALL = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'hE0, 8'h00, 8'h00, 8'h27, 8'h00, 8'h00, 8'h10,
      8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [BITS-1:0] RO_ALL = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
      8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20,
      8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

   localparam logic            CELL_RESET = 1'b0;
   localparam logic [BITS-1:0] BIT_ONE    = {{(BITS-1){1'b0}}, 1'b1};
   localparam logic [BITS-1:0] BYTE_ONES  = {{(BITS-REG_W){1'b0}}, 8'hFF};

   // ---------------------------------------------------------------
   // Core operations
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ     = 3'b000,
      OP_WRITE    = 3'b001,
      OP_SET_BIT  = 3'b010,
      OP_CLR_BIT  = 3'b011,
      OP_SKIP_SET = 3'b100,
      OP_SKIP_CLR = 3'b101
   } iorba_op_t;

endpackage

//--- rtl/iorba_pin_sync.sv
// Two-stage synchroniser for port pin levels
`timescale 1ns/1ps
`default_nettype none
module iorba_pin_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // Pins and synchronised copy
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinOut
);
   logic [W-1:0] stage1_ff;
   logic [W-1:0] stage2_ff;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= pinIn;
         stage2_ff <= stage1_ff;
      end
   end

   assign pinOut = stage2_ff;
endmodule
`default_nettype wire

//--- rtl/iorba_flag_bit.sv
// Status flag cell: hardware sets, writing one clears
`timescale 1ns/1ps
`default_nettype none
module iorba_flag_bit (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Set, clear and state
   input  wire logic setIn,
   input  wire logic clrIn,
   output logic      q
);
   import iorba_pkg::*;

   logic flag_ff;

   // Set beats clear so a coinciding event is never lost
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flag_ff <= CELL_RESET;
      end else if (setIn) begin
         flag_ff <= 1'b1;
      end else if (clrIn) begin
         flag_ff <= 1'b0;
      end
   end

   assign q = flag_ff;
endmodule
`default_nettype wire

//--- rtl/io_register_bit_access.sv
// Lower I/O register bank with byte and single-bit access
`timescale 1ns/1ps
`default_nettype none
module io_register_bit_access (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // Core request
   input  wire logic                  reqValid,
   input  wire iorba_pkg::iorba_op_t  reqOp,
   input  wire logic                  reqDataSpace,
   input  wire logic [7:0]            reqAddr,
   input  wire logic [2:0]            reqBit,
   input  wire logic [7:0]            reqWdata,
   // Core answer
   output logic                       rspValid,
   output logic                       rspErr,
   output logic                       rspSkip,
   output logic [7:0]                 rspRdata,
   // Peripheral side
   input  wire logic [iorba_pkg::BITS-1:0] flagSet,
   input  wire logic [iorba_pkg::BITS-1:0] roIn,
   input  wire logic [7:0]            port_a_input,
   input  wire logic [3:0]            port_b_input,
   output logic [iorba_pkg::BITS-1:0] regOut
);
   import iorba_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic            ioSpace;
   logic            inIo;
   logic            inData;
   logic            mapped;
   logic [4:0]      effAddr;
   logic [7:0]      bitIdx;
   logic            isRsvd;
   logic            isBitOp;
   logic            isSkip;
   logic            isStore;
   logic            opValid;
   logic            reqErr;
   logic            writeHit;
   logic            bitOpHit;
   logic            setOp;
   logic            wantSet;
   logic [BITS-1:0] wrSel;
   logic [BITS-1:0] wrBits;
   logic [BITS-1:0] bitSel;
   logic [BITS-1:0] nxtBits;
   logic [BITS-1:0] clrBits;
   logic [BITS-1:0] regBits;
   logic [BITS-1:0] pinBits;
   logic [BITS-1:0] liveBits;
   logic [BITS-1:0] byteView;
   logic [7:0]      readByte;
   logic            bitVal;
   logic [7:0]      pinASync;
   logic [3:0]      pinBSync;
   logic [7:0]      nxt_rdata;
   logic            nxt_skip;
   logic            rspValid_ff;
   logic            rspErr_ff;
   logic            rspSkip_ff;
   logic [7:0]      rspRdata_ff;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   iorba_pin_sync #(
      .W       (8)
   ) u_sync_a (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (port_a_input),
      .pinOut  (pinASync)
   );

   iorba_pin_sync #(
      .W       (4)
   ) u_sync_b (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pinIn   (port_b_input),
      .pinOut  (pinBSync)
   );

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   assign ioSpace = !reqDataSpace;
   assign inIo    = ioSpace && (reqAddr < IO_TOP);
   // Data space mirror sits one window above the I/O numbers
   assign inData  = reqDataSpace && (reqAddr >= DATA_OFS)
                    && (reqAddr < DATA_TOP);
   assign mapped  = inIo || inData;
   assign effAddr = reqAddr[4:0];
   assign bitIdx  = {effAddr, reqBit};

   assign isRsvd  = (effAddr == OFS_RESERVED_IO_02)
                    || (effAddr == OFS_RESERVED_IO_09)
                    || (effAddr == OFS_RESERVED_IO_0A)
                    || (effAddr == OFS_RESERVED_IO_11);

   assign isBitOp = (reqOp == OP_SET_BIT) || (reqOp == OP_CLR_BIT);
   assign isSkip  = (reqOp == OP_SKIP_SET) || (reqOp == OP_SKIP_CLR);
   assign isStore = (reqOp == OP_WRITE) || isBitOp;
   assign opValid = isStore || isSkip || (reqOp == OP_READ);
   assign setOp   = (reqOp == OP_SET_BIT);
   assign wantSet = (reqOp == OP_SKIP_SET);

   // Bit operations only in the I/O window, never via data space
   assign reqErr  = !opValid
                    || !mapped
                    || ((isBitOp || isSkip) && !inIo)
                    || (isStore && isRsvd);

   assign writeHit = reqValid && !reqErr && (reqOp == OP_WRITE);
   assign bitOpHit = reqValid && !reqErr && isBitOp;

   // ---------------------------------------------------------------
   // Write steering
   // ---------------------------------------------------------------
   // Byte write lanes, placed at the addressed register
   assign wrSel  = writeHit ? (BYTE_ONES << {effAddr, 3'h0}) : '0;
   assign wrBits = writeHit
                   ? ({{(BITS-REG_W){1'b0}}, reqWdata} << {effAddr, 3'h0})
                   : '0;
   // Single-bit operations select one cell only
   assign bitSel = bitOpHit ? (BIT_ONE << bitIdx) : '0;

   // Plain storage cells: byte write, else bit op, else hold
   assign nxtBits = (wrSel & wrBits)
                    | (~wrSel & bitSel & {BITS{setOp}})
                    | (~wrSel & ~bitSel & regBits);

   // Flag cells: a one written, or a set-bit on that very cell, clears
   assign clrBits = wrBits | (bitSel & {BITS{setOp}});

   // ---------------------------------------------------------------
   // Register cells
   // ---------------------------------------------------------------
   // Reserved and read-only positions hold no state, so writes vanish
   for (genvar i = 0; i < BITS; i++) begin : g_bit
      if (W1C_ALL[i]) begin : g_flag
         iorba_flag_bit u_flag (
            .ref_clk (ref_clk),
            .rst     (rst),
            .setIn   (flagSet[i]),
            .clrIn   (clrBits[i]),
            .q       (regBits[i])
         );
      end else if (RW_ALL[i]) begin : g_rw
         logic cell_ff;
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               cell_ff <= CELL_RESET;
            end else begin
               cell_ff <= nxtBits[i];
            end
         end
         assign regBits[i] = cell_ff;
      end else begin : g_none
         assign regBits[i] = CELL_RESET;
      end
   end

   assign regOut = regBits;

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   assign pinBits = ({{(BITS-8){1'b0}}, pinASync} << {OFS_PORT_A_INPUT, 3'h0})
                    | ({{(BITS-4){1'b0}}, pinBSync} << {OFS_PORT_B_INPUT, 3'h0});

   // Stored state, live peripheral bits and pin levels merge here
   assign liveBits = (regBits & (RW_ALL | W1C_ALL))
                     | (roIn & RO_ALL)
                     | pinBits;

   assign byteView = liveBits >> {effAddr, 3'h0};
   assign readByte = byteView[7:0];
   assign bitVal   = liveBits[bitIdx];

   assign nxt_rdata = (reqValid && !reqErr && (reqOp == OP_READ))
                      ? readByte : 8'h00;
   // Skip when the tested bit equals the wanted level
   assign nxt_skip  = reqValid && !reqErr && isSkip
                      && (bitVal == wantSet);

   // ---------------------------------------------------------------
   // Answer registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rspValid_ff <= 1'b0;
         rspErr_ff   <= 1'b0;
         rspSkip_ff  <= 1'b0;
         rspRdata_ff <= 8'h00;
      end else begin
         rspValid_ff <= reqValid;
         rspErr_ff   <= reqValid && reqErr;
         rspSkip_ff  <= nxt_skip;
         rspRdata_ff <= nxt_rdata;
      end
   end

   assign rspValid = rspValid_ff;
   assign rspErr   = rspErr_ff;
   assign rspSkip  = rspSkip_ff;
   assign rspRdata = rspRdata_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic            rwHere;
   logic [BITS-1:0] rwView;
   logic [BITS-1:0] clrTarget;
   logic [BITS-1:0] keepFlags;

   assign rwHere    = RW_ALL[bitIdx];
   assign rwView    = regBits & RW_ALL;
   assign clrTarget = clrBits & W1C_ALL & ~flagSet;
   assign keepFlags = regBits & W1C_ALL & ~bitSel;

   sequence s_set_req;
      reqValid && (reqOp == OP_SET_BIT) && inIo && rwHere;
   endsequence

   sequence s_skip_req;
      reqValid && isSkip && inIo;
   endsequence

   sequence s_data_store;
      reqValid && (reqOp == OP_WRITE) && inData && !isRsvd;
   endsequence

   property p_set_bit;
      @(posedge ref_clk) disable iff (rst)
      s_set_req |=> regBits[$past(bitIdx)];
   endproperty
   a_set_bit: assert property (p_set_bit)
      else $error("set-bit did not set the addressed cell");

   property p_bit_range;
      @(posedge ref_clk) disable iff (rst)
      (reqValid && (isBitOp || isSkip) && !inIo)
         |=> rspErr && $stable(rwView) && !rspSkip;
   endproperty
   a_bit_range: assert property (p_bit_range)
      else $error("bit operation outside I/O window was not refused");

   property p_skip;
      @(posedge ref_clk) disable iff (rst)
      s_skip_req |=> rspValid && !rspErr
                     && (rspSkip == ($past(bitVal) == $past(wantSet)));
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip answer disagrees with tested bit");

   property p_w1c;
      @(posedge ref_clk) disable iff (rst)
      (|clrTarget) |=> ((regBits & $past(clrTarget)) == '0);
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("flag written with one was not cleared");

   property p_bit_only;
      @(posedge ref_clk) disable iff (rst)
      bitOpHit |=> ((regBits & $past(keepFlags)) == $past(keepFlags));
   endproperty
   a_bit_only: assert property (p_bit_only)
      else $error("bit operation cleared another flag");

   property p_data_mirror;
      @(posedge ref_clk) disable iff (rst)
      s_data_store |=> ((regBits & RW_ALL & $past(wrSel))
                        == ($past(wrBits) & RW_ALL & $past(wrSel)));
   endproperty
   a_data_mirror: assert property (p_data_mirror)
      else $error("data space store missed the I/O register");

   // ---------------------------------------------------------------
   // Further checks
   // ---------------------------------------------------------------
   logic            clrRwReq;
   logic            clrFlagReq;
   logic            readReq;
   logic [BITS-1:0] hwSet;
   logic [BITS-1:0] rwMaskView;
   logic [BITS-1:0] cellView;

   assign clrRwReq   = reqValid && (reqOp == OP_CLR_BIT) && inIo && rwHere;
   // A flag raised in the same cycle rightly reads back as one
   assign clrFlagReq = reqValid && (reqOp == OP_CLR_BIT) && inIo
                       && W1C_ALL[bitIdx] && !flagSet[bitIdx];
   assign readReq    = reqValid && !reqErr && (reqOp == OP_READ);
   assign hwSet      = flagSet & W1C_ALL;
   assign rwMaskView = RW_ALL >> {effAddr, 3'h0};
   assign cellView   = regBits >> {effAddr, 3'h0};

   sequence s_clr_req;
      clrRwReq;
   endsequence

   sequence s_answer;
      rspValid && !rspErr;
   endsequence

   property p_clr_bit;
      @(posedge ref_clk) disable iff (rst)
      s_clr_req |=> !regBits[$past(bitIdx)];
   endproperty
   a_clr_bit: assert property (p_clr_bit)
      else $error("clear-bit did not clear the addressed cell");

   property p_bit_accept;
      @(posedge ref_clk) disable iff (rst)
      (reqValid && isBitOp && inIo && !isRsvd) |=> s_answer ##0 !rspSkip;
   endproperty
   a_bit_accept: assert property (p_bit_accept)
      else $error("bit operation inside I/O window was refused");

   property p_skip_only;
      @(posedge ref_clk) disable iff (rst)
      (reqValid && !isSkip) |=> !rspSkip;
   endproperty
   a_skip_only: assert property (p_skip_only)
      else $error("skip raised by a request that tests no bit");

   property p_flag_set;
      @(posedge ref_clk) disable iff (rst)
      (|hwSet) |=> ((regBits & $past(hwSet)) == $past(hwSet));
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("hardware flag event was lost");

   property p_clr_flag;
      @(posedge ref_clk) disable iff (rst)
      clrFlagReq |=> (regBits[$past(bitIdx)] == $past(regBits[bitIdx]));
   endproperty
   a_clr_flag: assert property (p_clr_flag)
      else $error("clear-bit changed a status flag");

   property p_read_mirror;
      @(posedge ref_clk) disable iff (rst)
      (readReq && inData)
         |=> ((rspRdata & $past(rwMaskView[7:0]))
              == ($past(cellView[7:0]) & $past(rwMaskView[7:0])));
   endproperty
   a_read_mirror: assert property (p_read_mirror)
      else $error("data space read disagrees with stored cells");

endmodule
`default_nettype wire

//--- bench/iorba_core_model.sv
// Processor-core model issuing I/O, data-space and bit requests
`timescale 1ns/1ps
`default_nettype none
module iorba_core_model (
   // Clock
   input  wire logic                 ref_clk,
   // Request to the bank
   output var  logic                 reqValid,
   output var  iorba_pkg::iorba_op_t reqOp,
   output var  logic                 reqDataSpace,
   output var  logic [7:0]           reqAddr,
   output var  logic [2:0]           reqBit,
   output var  logic [7:0]           reqWdata,
   // Answer from the bank
   input  wire logic                 rspValid,
   input  wire logic                 rspErr,
   input  wire logic                 rspSkip,
   input  wire logic [7:0]           rspRdata
);
   import iorba_pkg::*;

   initial begin
      reqValid     = 1'b0;
      reqOp        = OP_READ;
      reqDataSpace = 1'b0;
      reqAddr      = 8'h00;
      reqBit       = 3'h0;
      reqWdata     = 8'h00;
   end

   // ---------------------------------------------------------------
   // One request, answer taken in the cycle after it is accepted
   // ---------------------------------------------------------------
   task automatic issue(input iorba_op_t op, input logic ds, input logic [7:0] addr,
                        input logic [2:0] bitIdx, input logic [7:0] wd,
                        output logic v, output logic err, output logic skip,
                        output logic [7:0] rd);
      @(posedge ref_clk);
      reqValid     <= 1'b1;
      reqOp        <= op;
      reqDataSpace <= ds;
      reqAddr      <= addr;
      reqBit       <= bitIdx;
      reqWdata     <= wd;
      @(posedge ref_clk);
      reqValid     <= 1'b0;
      // Released address, data and bit lines must not keep the old value
      reqAddr      <= ~addr;
      reqWdata     <= ~wd;
      reqBit       <= ~bitIdx;
      #1;
      v    = rspValid;
      err  = rspErr;
      skip = rspSkip;
      rd   = rspRdata;
   endtask
endmodule
`default_nettype wire

//--- bench/test_io_register_bit_access.sv
// Self-checking bench for the lower I/O register bank
`timescale 1ns/1ps
`default_nettype none
module test_io_register_bit_access;
   import iorba_pkg::*;

   logic             ref_clk;
   logic             rst;
   logic             reqValid;
   iorba_op_t        reqOp;
   logic             reqDataSpace;
   logic [7:0]       reqAddr;
   logic [2:0]       reqBit;
   logic [7:0]       reqWdata;
   logic             rspValid;
   logic             rspErr;
   logic             rspSkip;
   logic [7:0]       rspRdata;
   logic [BITS-1:0]  flagSet;
   logic [BITS-1:0]  roIn;
   logic [7:0]       port_a_input;
   logic [3:0]       port_b_input;
   logic [BITS-1:0]  regOut;
   int               error_cnt;
   int               tests_run;

   initial ref_clk = 1'b0;
   always #2.5 ref_clk = ~ref_clk;

   io_register_bit_access u_dut (
      .ref_clk(ref_clk), .rst(rst), .reqValid(reqValid), .reqOp(reqOp),
      .reqDataSpace(reqDataSpace), .reqAddr(reqAddr), .reqBit(reqBit),
      .reqWdata(reqWdata), .rspValid(rspValid), .rspErr(rspErr), .rspSkip(rspSkip),
      .rspRdata(rspRdata), .flagSet(flagSet), .roIn(roIn), .port_a_input(port_a_input), .port_b_input(port_b_input),
      .regOut(regOut));

   iorba_core_model u_core (
      .ref_clk(ref_clk), .reqValid(reqValid), .reqOp(reqOp), .reqDataSpace(reqDataSpace),
      .reqAddr(reqAddr), .reqBit(reqBit), .reqWdata(reqWdata), .rspValid(rspValid),
      .rspErr(rspErr), .rspSkip(rspSkip), .rspRdata(rspRdata));

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic op(input iorba_op_t o, input logic ds, input logic [7:0] a,
                     input logic [2:0] b, input logic [7:0] w, input logic eErr,
                     input logic eSkip, input logic [7:0] eRd);
      logic       v;
      logic       err;
      logic       skip;
      logic [7:0] rd;
      u_core.issue(o, ds, a, b, w, v, err, skip, rd);
      chk({5'h00, v, err, skip}, {5'h00, 1'b1, eErr, eSkip});
      chk(rd, eRd);
   endtask

   task automatic results();
      $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_bytes();
      logic [7:0] m;
      logic [7:0] rw;
      logic       rsvd;
      iorba_op_t  wop;
      for (int a = 0; a < NREG; a++) begin
         op(OP_READ, 1'b1, 8'(a) + DATA_OFS, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00);
      end
      for (int a = 0; a < NREG; a++) begin
         m    = RW_ALL[a*8+:8] | W1C_ALL[a*8+:8] | RO_ALL[a*8+:8];
         rw   = RW_ALL[a*8+:8];
         rsvd = (a == 2 || a == 9 || a == 10 || a == 17);
         // Reserved addresses are only ever read, never written
         wop  = rsvd ? OP_READ : OP_WRITE;
         op(wop, 1'b0, 8'(a), 3'h0, 8'hFF & m, 1'b0, 1'b0, 8'h00);
         op(OP_READ, 1'b1, 8'(a) + DATA_OFS, 3'h0, 8'h00, 1'b0, 1'b0, rw);
         chk(regOut[a*8+:8] & rw, rw);
         op(wop, 1'b1, 8'(a) + DATA_OFS, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00);
         op(OP_READ, 1'b0, 8'(a), 3'h0, 8'h00, 1'b0, 1'b0, 8'h00);
      end
      op(OP_SKIP_CLR, 1'b0, 8'h02, 3'h0, 8'h00, 1'b0, 1'b1, 8'h00);
      op(OP_READ, 1'b0, IO_TOP, 3'h0, 8'h00, 1'b1, 1'b0, 8'h00);
      op(OP_READ, 1'b1, DATA_TOP, 3'h0, 8'h00, 1'b1, 1'b0, 8'h00);
      op(OP_READ, 1'b1, 8'h1F, 3'h0, 8'h00, 1'b1, 1'b0, 8'h00);
      op(iorba_op_t'(3'b110), 1'b0, 8'h13, 3'h0, 8'h00, 1'b1, 1'b0, 8'h00);
   endtask

   task automatic t_bitops();
      op(OP_SET_BIT, 1'b0, 8'h1B, 3'h3, 8'h00, 1'b0, 1'b0, 8'h00);
      chk(regOut[8'h1B*8+:8], 8'h08);
      op(OP_SET_BIT, 1'b0, 8'h1B, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_CLR_BIT, 1'b0, 8'h1B, 3'h3, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_READ, 1'b0, 8'h1B, 3'h0, 8'h00, 1'b0, 1'b0, 8'h01);
      op(OP_SET_BIT, 1'b0, 8'h1F, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_READ, 1'b0, 8'h1F, 3'h0, 8'h00, 1'b0, 1'b0, 8'h01);
      op(OP_SET_BIT, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_READ, 1'b0, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 8'h01);
      op(OP_SET_BIT, 1'b1, 8'h3B, 3'h1, 8'h00, 1'b1, 1'b0, 8'h00);
      op(OP_SET_BIT, 1'b0, IO_TOP, 3'h1, 8'h00, 1'b1, 1'b0, 8'h00);
      op(OP_SKIP_CLR, 1'b0, 8'h11, 3'h1, 8'h00, 1'b0, 1'b1, 8'h00);
      chk(regOut[8'h1B*8+:8], 8'h01);
   endtask

   task automatic t_skip();
      op(OP_SKIP_SET, 1'b0, 8'h1B, 3'h0, 8'h00, 1'b0, 1'b1, 8'h00);
      op(OP_SKIP_SET, 1'b0, 8'h1B, 3'h1, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_SKIP_CLR, 1'b0, 8'h1B, 3'h1, 8'h00, 1'b0, 1'b1, 8'h00);
      op(OP_SKIP_CLR, 1'b0, 8'h1B, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_SKIP_SET, 1'b0, 8'h1F, 3'h0, 8'h00, 1'b0, 1'b1, 8'h00);
      op(OP_SKIP_SET, 1'b1, 8'h3B, 3'h0, 8'h00, 1'b1, 1'b0, 8'h00);
      op(OP_SKIP_CLR, 1'b0, IO_TOP, 3'h0, 8'h00, 1'b1, 1'b0, 8'h00);
   endtask

   task automatic t_flags();
      op(OP_WRITE, 1'b0, 8'h08, 3'h0, 8'h0E, 1'b0, 1'b0, 8'h00);
      @(posedge ref_clk);
      flagSet[8'h0B*8+:8] <= 8'h27;
      flagSet[8'h08*8+:8] <= 8'h10;
      @(posedge ref_clk);
      flagSet <= '0;
      op(OP_READ, 1'b0, 8'h0B, 3'h0, 8'h00, 1'b0, 1'b0, 8'h27);
      op(OP_WRITE, 1'b0, 8'h0B, 3'h0, 8'h01, 1'b0, 1'b0, 8'h00);
      op(OP_READ, 1'b0, 8'h0B, 3'h0, 8'h00, 1'b0, 1'b0, 8'h26);
      op(OP_SET_BIT, 1'b0, 8'h0B, 3'h1, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_CLR_BIT, 1'b0, 8'h0B, 3'h2, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_READ, 1'b0, 8'h0B, 3'h0, 8'h00, 1'b0, 1'b0, 8'h24);
      op(OP_SET_BIT, 1'b0, 8'h08, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_READ, 1'b0, 8'h08, 3'h0, 8'h00, 1'b0, 1'b0, 8'h1F);
      op(OP_SET_BIT, 1'b0, 8'h08, 3'h4, 8'h00, 1'b0, 1'b0, 8'h00);
      op(OP_READ, 1'b1, 8'h28, 3'h0, 8'h00, 1'b0, 1'b0, 8'h0F);
   endtask

   task automatic t_ro();
      @(posedge ref_clk);
      roIn[8'h04*8+:8] <= 8'h5A;
      port_a_input             <= 8'hC3;
      port_b_input             <= 4'hA;
      repeat (4) @(posedge ref_clk);
      op(OP_WRITE, 1'b0, 8'h04, 3'h0, 8'hFF, 1'b0, 1'b0, 8'h00);
      op(OP_READ, 1'b0, 8'h04, 3'h0, 8'h00, 1'b0, 1'b0, 8'h5A);
      op(OP_READ, 1'b1, 8'h39, 3'h0, 8'h00, 1'b0, 1'b0, 8'hC3);
      op(OP_SKIP_SET, 1'b0, 8'h16, 3'h1, 8'h00, 1'b0, 1'b1, 8'h00);
      op(OP_READ, 1'b0, 8'h16, 3'h0, 8'h00, 1'b0, 1'b0, 8'h0A);
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      error_cnt = 0;
      tests_run = 0;
      rst       = 1'b1;
      flagSet   = '0;
      roIn      = '0;
      port_a_input      = 8'h00;
      port_b_input      = 4'h0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_bytes();
      t_bitops();
      t_skip();
      t_flags();
      t_ro();
      results();
   end

   // About 200 requests of two cycles each; generous margin
   initial begin
      #100000;
      error_cnt++;
      results();
   end
endmodule
`default_nettype wire
